// File: mic_regs.svh
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// ==========================================
// io data addresses
`define MIC_ADDR_PA_CMP 8'h74
`define MIC_ADDR_PA_MASK 8'h75
`define MIC_ADDR_SW_MASK 8'h76
`define MIC_ADDR_PB_CTL 8'h77
`define MIC_ADDR_TMR_MASK 8'h78
`define MIC_ADDR_TMR_FLAG 8'h79
`define MIC_ADDR_PS_FLAG 8'h7A

// ==========================================
// field positions
`define MIC_PB_MASK_BIT 2
`define MIC_PB_CMP_BIT 1
`define MIC_PB_PIN_BIT 0
`define MIC_STEP_PB 0
`define MIC_STEP_PA 1
`define MIC_STEP_TMR 2
`define MIC_STEP_SW 3

// ==========================================
// reset values and timing
`define MIC_RST_NIBBLE 4'h0
`define MIC_ENTRY_CYCLES 12
`define MIC_STACK_WORDS 3
`define MIC_VEC_PAGE 4'h1
`define MIC_VEC_MID 4'h0

`endif

// File: mic_pkg.sv
package mic_pkg;
	// ==========================================
	// port and stopwatch flag nibble layout
	typedef struct packed {
		logic port_b;
		logic port_a;
		logic sw_1hz;
		logic sw_10hz;
	} mic_ps_flags_t;

	// ==========================================
	// cpu entry signals
	typedef struct packed {
		logic push;
		logic load;
		logic [11:0] vector;
	} mic_entry_t;

	typedef enum logic [0:0] {MIC_IDLE, MIC_ENTRY} mic_state_t;
endpackage

// File: mic_interrupt_control.sv
// Function
// - port A flag sets when masked pins go from matching compare to mismatching
// - port B flag sets on the pin edge chosen by its compare bit
// - request only when flag and mask are one and global enable is one
// - factor flags are read only and clear when their register is read
// - timer and stopwatch flags set even while their masks are zero
// - accepting an interrupt clears the global enable flag
// - entry pushes three stack words and loads the vector after 12 cycles
// - vector step bits: port B, port A, timer, stopwatch, in page one
// - vector slots start at 101H, one per nonzero step, ascending
// - enable instruction sets global enable, pending requests may then wake
// - timer falling edges set 079H flags, stopwatch set 07AH low flags
// - halt stops the cpu clock, an accepted interrupt restarts it
`timescale 1ns/1ps
`include "mic_regs.svh"

module mic_interrupt_control
	import mic_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// io data bus from cpu
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [3:0] io_wdata,
	output logic [3:0] io_rdata_r,
	// factor sources
	input wire logic [3:0] port_a_pins,
	input wire logic port_b_pin,
	input wire logic [2:0] clock_pulses,
	input wire logic [1:0] stopwatch_pulses,
	// cpu instructions
	input wire logic irq_unmask_all_instr,
	input wire logic irq_mask_all_instr,
	input wire logic halt_instr,
	// cpu control
	output logic gie_r,
	output logic halt_r,
	output logic busy_r,
	output logic [3:0] vector_step_r,
	output mic_entry_t entry_r
);

	// ==========================================
	// storage
	logic [3:0] pa_cmp_r;
	logic [3:0] port_a_masks_r;
	logic [1:0] stopwatch_masks_r;
	logic port_b_mask_r;
	logic port_b_cmp_r;
	logic [2:0] clock_pulse_masks_r;
	logic [2:0] clock_pulse_flags_r;
	mic_ps_flags_t ps_flags_r;
	logic pa_match_r;
	logic pb_prev_r;
	logic [2:0] tmr_prev_r;
	logic [1:0] sw_prev_r;
	logic init_r;
	mic_state_t state_r;
	logic [3:0] cnt_r;

	// ==========================================
	// decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	logic rd_tmr, rd_ps, pa_match, pa_set, pb_set, accept;
	logic [2:0] tmr_set;
	logic [1:0] sw_set;
	logic [3:0] group_req;

	assign rd_tmr = io_rd && hit(io_addr, `MIC_ADDR_TMR_FLAG);
	assign rd_ps = io_rd && hit(io_addr, `MIC_ADDR_PS_FLAG);
	assign pa_match = (((port_a_pins ^ pa_cmp_r) & port_a_masks_r) == 4'h0);
	assign pa_set = init_r && pa_match_r && !pa_match;
	assign pb_set = init_r && (port_b_cmp_r ? (pb_prev_r && !port_b_pin)
		: (!pb_prev_r && port_b_pin));
	assign tmr_set = {3{init_r}} & tmr_prev_r & ~clock_pulses;
	assign sw_set = {2{init_r}} & sw_prev_r & ~stopwatch_pulses;

	// ==========================================
	// group requests and acceptance
	always_comb begin
		group_req = 4'h0;
		group_req[`MIC_STEP_PB] = ps_flags_r.port_b && port_b_mask_r;
		group_req[`MIC_STEP_PA] = ps_flags_r.port_a && (|port_a_masks_r);
		group_req[`MIC_STEP_TMR] = |(clock_pulse_flags_r & clock_pulse_masks_r);
		group_req[`MIC_STEP_SW] = |({ps_flags_r.sw_1hz, ps_flags_r.sw_10hz}
			& stopwatch_masks_r);
	end

	assign accept = (state_r == MIC_IDLE) && gie_r && (group_req != 4'h0);

	// ==========================================
	// sample history
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			init_r <= 1'b0;
			pa_match_r <= 1'b0;
			pb_prev_r <= 1'b0;
			tmr_prev_r <= 3'h0;
			sw_prev_r <= 2'h0;
		end else begin
			init_r <= 1'b1;
			pa_match_r <= pa_match;
			pb_prev_r <= port_b_pin;
			tmr_prev_r <= clock_pulses;
			sw_prev_r <= stopwatch_pulses;
		end
	end

	// ==========================================
	// writable registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pa_cmp_r <= `MIC_RST_NIBBLE;
			port_a_masks_r <= `MIC_RST_NIBBLE;
			stopwatch_masks_r <= 2'h0;
			port_b_mask_r <= 1'b0;
			port_b_cmp_r <= 1'b0;
			clock_pulse_masks_r <= 3'h0;
		end else if (io_wr) begin
			case (io_addr)
				`MIC_ADDR_PA_CMP: pa_cmp_r <= io_wdata;
				`MIC_ADDR_PA_MASK: port_a_masks_r <= io_wdata;
				`MIC_ADDR_SW_MASK: stopwatch_masks_r <= io_wdata[1:0];
				`MIC_ADDR_PB_CTL: begin
					port_b_mask_r <= io_wdata[`MIC_PB_MASK_BIT];
					port_b_cmp_r <= io_wdata[`MIC_PB_CMP_BIT];
				end
				`MIC_ADDR_TMR_MASK: clock_pulse_masks_r <= io_wdata[2:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// factor flags, set wins over read clear
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clock_pulse_flags_r <= 3'h0;
		end else begin
			clock_pulse_flags_r <= (rd_tmr ? 3'h0 : clock_pulse_flags_r) | tmr_set;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ps_flags_r <= mic_ps_flags_t'(`MIC_RST_NIBBLE);
		end else begin
			ps_flags_r <= (rd_ps ? mic_ps_flags_t'(4'h0) : ps_flags_r)
				| mic_ps_flags_t'({pb_set, pa_set, sw_set});
		end
	end

	// ==========================================
	// read data
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			io_rdata_r <= `MIC_RST_NIBBLE;
		end else if (io_rd) begin
			case (io_addr)
				`MIC_ADDR_PA_CMP: io_rdata_r <= pa_cmp_r;
				`MIC_ADDR_PA_MASK: io_rdata_r <= port_a_masks_r;
				`MIC_ADDR_SW_MASK: io_rdata_r <= {2'h0, stopwatch_masks_r};
				`MIC_ADDR_PB_CTL: io_rdata_r <= {1'b0, port_b_mask_r, port_b_cmp_r, port_b_pin};
				`MIC_ADDR_TMR_MASK: io_rdata_r <= {1'b0, clock_pulse_masks_r};
				`MIC_ADDR_TMR_FLAG: io_rdata_r <= {1'b0, clock_pulse_flags_r};
				`MIC_ADDR_PS_FLAG: io_rdata_r <= ps_flags_r;
				default: io_rdata_r <= 4'h0;
			endcase
		end
	end

	// ==========================================
	// global enable flag
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gie_r <= 1'b0;
		end else if (accept) begin
			gie_r <= 1'b0;
		end else if (irq_unmask_all_instr) begin
			gie_r <= 1'b1;
		end else if (irq_mask_all_instr) begin
			gie_r <= 1'b0;
		end
	end

	// ==========================================
	// halt and wake
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			halt_r <= 1'b0;
		end else if (accept) begin
			halt_r <= 1'b0;
		end else if (halt_instr) begin
			halt_r <= 1'b1;
		end
	end

	// ==========================================
	// entry sequencer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= MIC_IDLE;
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			vector_step_r <= 4'h0;
		end else begin
			case (state_r)
				MIC_IDLE: begin
					if (accept) begin
						state_r <= MIC_ENTRY;
						cnt_r <= 4'h0;
						busy_r <= 1'b1;
						vector_step_r <= group_req;
					end
				end
				MIC_ENTRY: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'(`MIC_ENTRY_CYCLES - 1)) begin
						state_r <= MIC_IDLE;
						busy_r <= 1'b0;
					end
				end
				default: state_r <= MIC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			entry_r <= '0;
		end else begin
			entry_r.push <= accept || (state_r == MIC_ENTRY
				&& cnt_r < 4'(`MIC_STACK_WORDS - 1));
			entry_r.load <= (state_r == MIC_ENTRY)
				&& (cnt_r == 4'(`MIC_ENTRY_CYCLES - 2));
			entry_r.vector <= {`MIC_VEC_PAGE, `MIC_VEC_MID, vector_step_r};
		end
	end

	// ==========================================
	// entry length watch
	logic [3:0] busy_len_r;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busy_len_r <= 4'h0;
		end else if (busy_r) begin
			busy_len_r <= busy_len_r + 4'h1;
		end else begin
			busy_len_r <= 4'h0;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_GIE_CLEAR: assert property (accept |=> !gie_r)
		else $error("global enable not cleared on accept");
	AST_ACCEPT_GATED: assert property (accept |-> gie_r && (group_req != 4'h0))
		else $error("accept without enable or request");
	AST_ENTRY_LEN: assert property (accept |-> ##12 entry_r.load)
		else $error("vector load not 12 cycles after accept");
	AST_PUSH_THREE: assert property (accept |=> entry_r.push [*3] ##1 !entry_r.push)
		else $error("stack push not three words");
	AST_VECTOR: assert property (entry_r.load |-> entry_r.vector == {8'h10, vector_step_r})
		else $error("wrong vector address");
	AST_STEP: assert property (accept |=> vector_step_r == $past(group_req))
		else $error("vector step does not match group requests");
	AST_RD_CLEAR: assert property (rd_tmr && tmr_set == 3'h0 |=> clock_pulse_flags_r == 3'h0)
		else $error("timer flags not cleared by read");
	AST_FLAG_UNMASKED: assert property (sw_set[0] && !stopwatch_masks_r[0] |=> ps_flags_r.sw_10hz)
		else $error("stopwatch flag lost while masked");
	AST_EI: assert property (irq_unmask_all_instr && !accept |=> gie_r)
		else $error("enable instruction did not set flag");
	AST_WAKE: assert property (halt_r && accept |=> !halt_r)
		else $error("halt not released on accept");
	AST_PB_EDGE: assert property (pb_set |=> ps_flags_r.port_b)
		else $error("port B edge lost");
	AST_BUSY_LEN: assert property (busy_r && busy_len_r == 4'hB |=> !busy_r)
		else $error("entry not ended after 12 cycles");
	AST_BUSY_MAX: assert property (busy_r |-> busy_len_r < 4'hC)
		else $error("entry longer than 12 cycles");
	AST_LOAD_POS: assert property (entry_r.load |-> busy_r && busy_len_r == 4'hB)
		else $error("vector load outside last entry cycle");
	AST_DI: assert property (irq_mask_all_instr && !irq_unmask_all_instr |=> !gie_r)
		else $error("disable instruction did not clear flag");

	COV_ACCEPT: cover property (accept ##12 entry_r.load);
	COV_WAKE: cover property (halt_r ##1 accept);
	COV_READ_CLEAR: cover property (rd_ps && ps_flags_r != mic_ps_flags_t'(4'h0));
	COV_ALL_GROUPS: cover property (accept && group_req == 4'hF);
	COV_PORT_A: cover property (accept && group_req == 4'h2);

endmodule

// File: mic_cpu_model.sv
`timescale 1ns/1ps
module mic_cpu_model
	import mic_pkg::*;
(
	// clock
	input wire logic clock,
	// io bus
	output logic [7:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [3:0] io_wdata,
	input wire logic [3:0] io_rdata_r,
	// instructions
	output logic [2:0] instr,
	// entry
	input wire logic busy_r,
	input wire mic_entry_t entry_r
);
	logic [11:0] pc_r;
	int pushes;
	int cyc;
	initial begin
		io_addr = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 4'h0;
		instr = 3'h0;
		pc_r = 12'h000;
	end
	// ==========================================
	// stack and program counter
	always @(posedge clock) begin
		if (busy_r) cyc <= cyc + 1;
		if (entry_r.push) pushes <= pushes + 1;
		if (entry_r.load) pc_r <= entry_r.vector;
	end
	task automatic clr();
		cyc = 0;
		pushes = 0;
	endtask
	// ==========================================
	// io bus cycles
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		@(posedge clock);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clock);
		io_wr <= 1'b0;
		io_addr <= ~a;
		io_wdata <= ~d;
	endtask
	// flags read only while global enable is off
	task automatic rd(input logic [7:0] a, output logic [3:0] d);
		@(posedge clock);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clock);
		io_rd <= 1'b0;
		io_addr <= ~a;
		#1 d = io_rdata_r;
	endtask
	// service order: port and stopwatch, then timer
	task automatic svc(output logic [3:0] ps, output logic [3:0] tm);
		rd(8'h7A, ps);
		rd(8'h79, tm);
	endtask
	// one hot {halt, disable, enable}
	task automatic ins(input logic [2:0] k);
		@(posedge clock);
		instr <= k;
		@(posedge clock);
		instr <= 3'h0;
	endtask
	task automatic wait_load(output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clock);
			if (entry_r.load === 1'b1) ok = 1'b1;
		end
		#1;
	endtask
endmodule

// File: mic_interrupt_control_tb.sv
`timescale 1ns/1ps
module mic_interrupt_control_tb
	import mic_pkg::*;
;
	logic clock, rst_n, io_wr, io_rd, port_b_pin, gie_r, halt_r, busy_r, ok;
	logic [7:0] io_addr;
	logic [3:0] io_wdata, io_rdata_r, port_a_pins, vector_step_r, d, t;
	logic [2:0] clock_pulses, instr;
	logic [1:0] stopwatch_pulses;
	mic_entry_t entry_r;
	int err_count, checks_done;
	mic_interrupt_control DUT (.clock(clock), .rst_n(rst_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
		.port_a_pins(port_a_pins), .port_b_pin(port_b_pin), .clock_pulses(clock_pulses),
		.stopwatch_pulses(stopwatch_pulses), .irq_unmask_all_instr(instr[0]),
		.irq_mask_all_instr(instr[1]), .halt_instr(instr[2]), .gie_r(gie_r),
		.halt_r(halt_r), .busy_r(busy_r), .vector_step_r(vector_step_r), .entry_r(entry_r));
	mic_cpu_model cpu (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .instr(instr), .busy_r(busy_r),
		.entry_r(entry_r));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================
	// shared entry check
	task automatic entry_chk(input logic [3:0] step);
		cpu.wait_load(ok);
		chk(12'(ok), 12'h001);
		chk(cpu.pc_r, {8'h10, step});
		chk(12'(cpu.pushes), 12'd3);
		chk(12'(cpu.cyc), 12'd12);
		chk({8'h0, vector_step_r}, {8'h0, step});
		chk({11'h0, gie_r}, 12'h000);
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs();
		for (int a = 8'h73; a <= 8'h7A; a++) begin
			cpu.rd(8'(a), d);
			chk({8'h0, d}, 12'h000);
		end
		cpu.wr(8'h7A, 4'hF);
		cpu.rd(8'h7A, d);
		chk({8'h0, d}, 12'h000);
	endtask
	task automatic t_timer();
		@(posedge clock) begin
			clock_pulses[2] <= 1'b0;
			stopwatch_pulses[0] <= 1'b0;
		end
		@(posedge clock) begin
			clock_pulses[2] <= 1'b1;
			stopwatch_pulses[0] <= 1'b1;
		end
		cpu.svc(d, t);
		chk({8'h0, d}, 12'h001);
		chk({8'h0, t}, 12'h004);
		cpu.rd(8'h79, t);
		chk({8'h0, t}, 12'h000);
	endtask
	task automatic t_port_b();
		cpu.wr(8'h77, 4'h4);
		cpu.ins(3'h1);
		cpu.clr();
		@(posedge clock) port_b_pin <= 1'b1;
		entry_chk(4'h1);
		cpu.svc(d, t);
		chk({8'h0, d}, 12'h008);
	endtask
	task automatic t_port_a();
		cpu.wr(8'h75, 4'h1);
		@(posedge clock) port_a_pins <= 4'h1;
		repeat (4) @(posedge clock);
		chk({11'h0, busy_r}, 12'h000);
		cpu.clr();
		cpu.ins(3'h1);
		entry_chk(4'h2);
		cpu.svc(d, t);
		chk({8'h0, d}, 12'h004);
	endtask
	task automatic t_halt();
		cpu.wr(8'h76, 4'h1);
		cpu.ins(3'h1);
		cpu.ins(3'h4);
		#1 chk({11'h0, halt_r}, 12'h001);
		cpu.clr();
		@(posedge clock) stopwatch_pulses[0] <= 1'b0;
		entry_chk(4'h8);
		chk({11'h0, halt_r}, 12'h000);
		cpu.svc(d, t);
		chk({8'h0, d}, 12'h001);
		cpu.ins(3'h1);
		#1 chk({11'h0, gie_r}, 12'h001);
		cpu.ins(3'h2);
		#1 chk({11'h0, gie_r}, 12'h000);
	endtask
	task automatic t_falling();
		cpu.wr(8'h77, 4'h2);
		cpu.wr(8'h74, 4'h1);
		@(posedge clock) begin
			port_b_pin <= 1'b0;
			port_a_pins <= 4'h0;
		end
		repeat (2) @(posedge clock);
		cpu.rd(8'h7A, d);
		chk({8'h0, d}, 12'h00C);
		cpu.rd(8'h77, d);
		chk({8'h0, d}, 12'h002);
	endtask
	initial begin
		rst_n = 1'b0;
		port_a_pins = 4'h0;
		port_b_pin = 1'b0;
		clock_pulses = 3'h7;
		stopwatch_pulses = 2'h3;
		err_count = 0;
		checks_done = 0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		t_regs();
		t_timer();
		t_port_b();
		t_port_a();
		t_halt();
		t_falling();
		final_report();
	end
	initial begin
		#50us;
		err_count++;
		final_report();
	end
endmodule
